// ===== sim/pin_partner.sv
// Outside world of the timer: channel pin drivers and clock pins
`timescale 1ns/100ps
`default_nettype none
module pin_partner #(
    parameter int NCH     = 2,
    parameter int FIX_DIV = 8,
    parameter int EXT_DIV = 4
) (
    // Clock
    input  wire logic           clk,
    // Bench controls
    input  wire logic           ext_run,
    input  wire logic [NCH-1:0] drive,
    // Channel pins
    input  wire logic [NCH-1:0] pin_out,
    input  wire logic [NCH-1:0] pin_oe_n,
    output logic      [NCH-1:0] pin_in,
    // Clock pins
    output logic                fixed_clock,
    output logic                external_count_clock
);
    int fix_cnt = 0;
    int ext_cnt = 0;

    // Timer owns the wire while it drives, else the outside driver
    assign pin_in = (pin_out & ~pin_oe_n) | (drive & pin_oe_n);
    assign fixed_clock = (fix_cnt < FIX_DIV / 2);
    // Stands low outside runs, quarter bus rate at most
    assign external_count_clock = ext_run && (ext_cnt >= EXT_DIV / 2);

    always @(posedge clk) begin
        fix_cnt <= (fix_cnt == FIX_DIV - 1) ? 0 : fix_cnt + 1;
        ext_cnt <= (!ext_run || ext_cnt == EXT_DIV - 1) ? 0 : ext_cnt + 1;
    end
endmodule
`default_nettype wire

// ===== sim/timer_capture_compare_pwm_test.sv
// Self-checking bench for the capture, compare and PWM timer
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defines.svh"
module timer_capture_compare_pwm_test;
    import tpm_pkg::*;
    localparam int NCH = 2;
    logic                 clk = 1'b0;
    logic                 arst_n = 1'b0;
    tmr_cfg_t             cfg = '0;
    logic                 background_debug_mode = 1'b0;
    logic                 cnt_wr = 1'b0;
    logic                 tof_clr = 1'b0;
    logic                 ext_run = 1'b0;
    ch_cfg_t [NCH-1:0]    ch_cfg = '0;
    logic [NCH-1:0][15:0] val_in = '0;
    logic [NCH-1:0]       val_wr = '0;
    logic [NCH-1:0]       flag_clr = '0;
    logic [NCH-1:0]       drive = '1;
    wire logic            fix_ck;
    wire logic            ext_ck;
    wire logic [NCH-1:0]  pin_in;
    wire logic [NCH-1:0]  pin_out;
    wire logic [NCH-1:0]  pin_oe_n;
    wire logic [15:0]     cnt;
    wire logic [NCH-1:0][15:0] ch_val;
    wire logic [NCH-1:0]  ch_flag;
    wire logic [NCH-1:0]  ch_irq;
    wire logic            tof_flag;
    wire logic            tof_irq;
    int                   mismatches = 0;
    int                   n_checks = 0;
    int                   cycles = 0;

    always #25 clk = ~clk;

    timer_capture_compare_pwm #(.NCH(NCH)) DUT (
        .CLK(clk), .ARST_N(arst_n), .TMR_CFG(cfg),
        .BACKGROUND_DEBUG_MODE(background_debug_mode), .COUNTER_WRITE(cnt_wr),
        .TOF_CLEAR(tof_clr), .CH_CFG(ch_cfg), .CHANNEL_VALUE_IN(val_in),
        .CHANNEL_VALUE_WRITE(val_wr), .CHANNEL_FLAG_CLEAR(flag_clr),
        .FIXED_CLOCK(fix_ck), .EXTERNAL_COUNT_CLOCK(ext_ck),
        .TIMER_CHANNEL_PIN_IN(pin_in), .TIMER_CHANNEL_PIN_OUT(pin_out),
        .TIMER_CHANNEL_PIN_OE_N(pin_oe_n), .COUNTER_VALUE(cnt),
        .CHANNEL_VALUE(ch_val), .CHANNEL_FLAG(ch_flag),
        .TOF_FLAG(tof_flag), .CHANNEL_IRQ(ch_irq), .TOF_IRQ(tof_irq));

    pin_partner #(.NCH(NCH)) PARTNER (
        .clk(clk), .ext_run(ext_run), .drive(drive), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .pin_in(pin_in), .fixed_clock(fix_ck),
        .external_count_clock(ext_ck));

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic setcfg(input logic c, input logic [1:0] s,
                          input logic [2:0] ps, input logic [15:0] m);
        @(posedge clk);
        cfg <= '{c, s, ps, m, 1'b1};
    endtask

    // Clears flags; counter restart optional
    task automatic clr(input logic restart);
        @(posedge clk);
        flag_clr <= '1;
        tof_clr <= 1'b1;
        cnt_wr <= restart;
        @(posedge clk);
        flag_clr <= '0;
        tof_clr <= 1'b0;
        cnt_wr <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_flag(input int ch);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((ch < 0 ? tof_flag : ch_flag[ch]) !== 1'b1 && n < 3000);
    endtask

    // Cycles between two terminal counts; drops a flag left from before
    task automatic period(output int p);
        @(posedge clk);
        tof_clr <= 1'b1;
        @(posedge clk);
        tof_clr <= 1'b0;
        wait_flag(-1);
        p = 0;
        do begin
            @(posedge clk);
            tof_clr <= (p == 0);
            @(negedge clk);
            p++;
        end while (!(p > 2 && tof_flag === 1'b1) && p < 3000);
    endtask

    task automatic highs(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge clk);
            h += (pin_out[1] === 1'b1);
        end
    endtask

    initial begin
        int p;
        logic [15:0] c;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        cyc(3);
        chk("reset counter", 16'h0000, cnt);
        chk("reset oe_n", 16'h0003, {14'h0, pin_oe_n});
        chk("reset flags", 16'h0000, {13'h0, ch_flag, tof_flag});
        for (int i = 0; i < 8; i++) begin
            setcfg(1'b0, `TPM_CLK_BUS, i[2:0], 16'h0003);
            period(p);
            chk("prescaled period", 16'(4 << i), 16'(p));
        end
        chk("tof irq", 16'h0001, {15'h0, tof_irq});
        setcfg(1'b0, `TPM_CLK_BUS, 3'h0, 16'h0008);
        period(p);
        chk("modulo period", 16'h0009, 16'(p));
        setcfg(1'b1, `TPM_CLK_BUS, 3'h0, 16'h0008);
        period(p);
        chk("center period", 16'h0010, 16'(p));
        setcfg(1'b0, `TPM_CLK_FIXED, 3'h0, 16'h0003);
        period(p);
        chk("fixed clock period", 16'h0020, 16'(p));
        ext_run <= 1'b1;
        setcfg(1'b0, `TPM_CLK_EXT, 3'h0, 16'h0003);
        period(p);
        chk("external period", 16'h0010, 16'(p));
        $display("Test counter periods done");
        for (int i = 0; i < 2; i++) begin
            setcfg(1'b0, `TPM_CLK_BUS, 3'h0, i ? 16'hFFFF : 16'h0000);
            clr(1'b1);
            chk("counter write", 16'h0000, cnt);
            cyc(40);
            chk("free run", 16'h0001, {15'h0, cnt > 16'h0020});
        end
        @(posedge clk);
        background_debug_mode <= 1'b1;
        cyc(3);
        c = cnt;
        cyc(10);
        chk("debug pause", c, cnt);
        @(posedge clk);
        background_debug_mode <= 1'b0;
        cyc(4);
        chk("debug resume", 16'h0001, {15'h0, cnt != c});
        $display("Test counter control done");
        for (int e = 0; e < 4; e++) begin
            @(posedge clk);
            ch_cfg[0] <= '{`TPM_MS_CAPTURE, e[1:0], 1'b1};
            drive[0] <= 1'b0;
            cyc(8);
            clr(1'b0);
            @(posedge clk);
            drive[0] <= 1'b1;
            cyc(8);
            chk("rise flag", {15'h0, e[0]}, {15'h0, ch_flag[0]});
            chk("rise irq", {15'h0, e[0]}, {15'h0, ch_irq[0]});
            chk("capture oe_n", 16'h0001, {15'h0, pin_oe_n[0]});
            if (e[0])
                chk("capture value", 16'h0001,
                    {15'h0, (cnt - ch_val[0]) inside {[2:10]}});
            clr(1'b0);
            @(posedge clk);
            drive[0] <= 1'b0;
            cyc(8);
            chk("fall flag", {15'h0, e[1]}, {15'h0, ch_flag[0]});
        end
        $display("Test capture done");
        setcfg(1'b0, `TPM_CLK_BUS, 3'h0, 16'h000F);
        val_in[1] <= 16'h0007;
        val_wr[1] <= 1'b1;
        @(posedge clk);
        val_wr[1] <= 1'b0;
        cyc(1);
        chk("value write", 16'h0007, ch_val[1]);
        for (int e = 3; e >= 0; e--) begin
            if (e == 0) begin
                ext_run <= 1'b1;
                setcfg(1'b0, `TPM_CLK_EXT, 3'h0, 16'h000F);
            end
            @(posedge clk);
            ch_cfg[1] <= '{`TPM_MS_COMPARE, e[1:0], 1'b0};
            clr(1'b1);
            wait_flag(1);
            chk("compare flag", 16'h0001, {15'h0, ch_flag[1]});
            chk("masked irq", 16'h0000, {15'h0, ch_irq[1]});
            chk("compare oe_n", {15'h0, e == 0}, {15'h0, pin_oe_n[1]});
            if (e != 0)
                chk("compare pin", {15'h0, e != 2}, {15'h0, pin_out[1]});
        end
        $display("Test compare done");
        setcfg(1'b0, `TPM_CLK_BUS, 3'h0, 16'h0008);
        val_in[1] <= 16'h0005;
        val_wr[1] <= 1'b1;
        for (int e = 2; e >= 1; e--) begin
            @(posedge clk);
            val_wr[1] <= 1'b0;
            ch_cfg[1] <= '{2'h2, e[1:0], 1'b1};
            clr(1'b0);
            cyc(20);
            chk("edge pwm flag", 16'h0001, {15'h0, ch_flag[1]});
            chk("pwm oe_n", 16'h0000, {15'h0, pin_oe_n[1]});
            highs(36, p);
            chk("edge pwm high", e == 2 ? 16'd20 : 16'd16, 16'(p));
        end
        setcfg(1'b1, `TPM_CLK_BUS, 3'h0, 16'h0008);
        @(posedge clk);
        ch_cfg[1] <= '{2'h2, 2'h2, 1'b1};
        cyc(40);
        highs(32, p);
        chk("center pwm high", 16'd20, 16'(p));
        setcfg(1'b0, `TPM_CLK_NONE, 3'h0, 16'h0008);
        cyc(3);
        c = cnt;
        cyc(10);
        chk("no clock", c, cnt);
        chk("no clock oe_n", 16'h0003, {14'h0, pin_oe_n});
        $display("Test pwm done");
        test_done();
    end
endmodule
`default_nettype wire

// ===== verilog/timer_capture_compare_pwm.sv
// Timer with capture, compare, edge and center PWM channels
`timescale 1ns/100ps
`default_nettype none
`include "tpm_defines.svh"
module timer_capture_compare_pwm
    import tpm_pkg::*;
#(
    parameter int NCH = 2
) (
    // Clock and reset
    input  wire logic                  CLK,
    input  wire logic                  ARST_N,
    // Module configuration
    input  wire tmr_cfg_t              TMR_CFG,
    input  wire logic                  BACKGROUND_DEBUG_MODE,
    input  wire logic                  COUNTER_WRITE,
    input  wire logic                  TOF_CLEAR,
    // Channel configuration
    input  wire ch_cfg_t [NCH-1:0]     CH_CFG,
    input  wire logic [NCH-1:0][15:0]  CHANNEL_VALUE_IN,
    input  wire logic [NCH-1:0]        CHANNEL_VALUE_WRITE,
    input  wire logic [NCH-1:0]        CHANNEL_FLAG_CLEAR,
    // Clock pins
    input  wire logic                  FIXED_CLOCK,
    input  wire logic                  EXTERNAL_COUNT_CLOCK,
    // Channel pins
    input  wire logic [NCH-1:0]        TIMER_CHANNEL_PIN_IN,
    output logic      [NCH-1:0]        TIMER_CHANNEL_PIN_OUT,
    output logic      [NCH-1:0]        TIMER_CHANNEL_PIN_OE_N,
    // Status
    output logic      [15:0]           COUNTER_VALUE,
    output logic      [NCH-1:0][15:0]  CHANNEL_VALUE,
    output logic      [NCH-1:0]        CHANNEL_FLAG,
    output logic                       TOF_FLAG,
    output logic      [NCH-1:0]        CHANNEL_IRQ,
    output logic                       TOF_IRQ
);
    function automatic logic [`TPM_PRE_W-1:0] pre_mask(
        input logic [2:0] ps
    );
        pre_mask = `TPM_PRE_W'((`TPM_PRE_W+1)'(1) << ps) - `TPM_PRE_ONE;
    endfunction

    function automatic logic els_edge(
        input logic [1:0] els,
        input logic       rise,
        input logic       fall
    );
        case (els)
            `TPM_ELS_RISE: els_edge = rise;
            `TPM_ELS_FALL: els_edge = fall;
            `TPM_ELS_BOTH: els_edge = rise | fall;
            default:       els_edge = 1'b0;
        endcase
    endfunction

    // Reset release
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    // Pin synchronizers and edge detect
    logic [NCH+1:0] pin_s;
    logic [NCH+1:0] pin_prev_r;
    logic [NCH+1:0] pin_rise;
    logic [NCH+1:0] pin_fall;

    tpm_sync2 #(.W(NCH+2)) u_sync (
        .clk   (CLK),
        .rst_n (rst_n),
        .d     ({EXTERNAL_COUNT_CLOCK, FIXED_CLOCK, TIMER_CHANNEL_PIN_IN}),
        .q     (pin_s)
    ); // R5 R24

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_r <= '0;
        end else begin
            pin_prev_r <= pin_s;
        end
    end
    assign pin_rise = pin_s & ~pin_prev_r;
    assign pin_fall = ~pin_s & pin_prev_r;

    // Clock select and prescaler
    logic                  clk_on;
    logic                  src_tick;
    logic                  cnt_tick;
    logic [`TPM_PRE_W-1:0] pre_r;
    logic [`TPM_PRE_W-1:0] pre_nxt;

    assign clk_on = TMR_CFG.clk_src != `TPM_CLK_NONE;

    always_comb begin
        case (TMR_CFG.clk_src)
            `TPM_CLK_BUS:   src_tick = 1'b1;
            `TPM_CLK_FIXED: src_tick = pin_rise[NCH]; // R5
            `TPM_CLK_EXT:   src_tick = pin_rise[NCH+1]; // R6
            default:        src_tick = 1'b0; // R4
        endcase
        cnt_tick = 1'b0;
        pre_nxt  = pre_r;
        if (COUNTER_WRITE) begin
            pre_nxt = `TPM_PRE_ZERO;
        end else if (src_tick && !BACKGROUND_DEBUG_MODE) begin // R11
            pre_nxt  = pre_r + `TPM_PRE_ONE;
            cnt_tick = (pre_r & pre_mask(TMR_CFG.prescale))
                       == pre_mask(TMR_CFG.prescale); // R3
        end
    end

    // Advances on each selected source tick outside debug mode; stop mode halts it by stopping CLK
    always_ff @(posedge CLK or negedge rst_n) begin // R12
        if (!rst_n) begin
            pre_r <= `TPM_PRE_ZERO;
        end else begin
            pre_r <= pre_nxt;
        end
    end

    // Main counter
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] limit;
    dir_t        dir_r;
    dir_t        dir_nxt;
    logic        adv_r;
    logic        adv_nxt;
    logic        tof_r;
    logic        tof_nxt;
    logic        tof_evt;

    always_comb begin
        limit = (TMR_CFG.modulo == `TPM_CNT_ZERO
                 || TMR_CFG.modulo == `TPM_CNT_FULL)
                ? `TPM_CNT_FULL : TMR_CFG.modulo; // R8
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        adv_nxt = 1'b0;
        tof_evt = 1'b0;
        if (COUNTER_WRITE) begin
            cnt_nxt = `TPM_CNT_ZERO; // R10
            dir_nxt = DIR_UP;
        end else if (cnt_tick) begin
            adv_nxt = 1'b1;
            if (!TMR_CFG.center) begin
                if (cnt_r >= limit) begin
                    cnt_nxt = `TPM_CNT_ZERO; // R7
                    tof_evt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + `TPM_CNT_ONE;
                end
            end else if (dir_r == DIR_UP) begin
                if (cnt_r >= limit) begin
                    dir_nxt = DIR_DOWN; // R18
                    cnt_nxt = cnt_r - `TPM_CNT_ONE;
                end else begin
                    cnt_nxt = cnt_r + `TPM_CNT_ONE;
                end
            end else if (cnt_r == `TPM_CNT_ZERO) begin
                dir_nxt = DIR_UP; // R18
                cnt_nxt = `TPM_CNT_ONE;
                tof_evt = 1'b1;
            end else begin
                cnt_nxt = cnt_r - `TPM_CNT_ONE;
            end
        end
        tof_nxt = tof_evt | (tof_r & ~TOF_CLEAR); // R26
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= `TPM_CNT_ZERO;
            dir_r <= DIR_UP;
            adv_r <= 1'b0;
            tof_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
            adv_r <= adv_nxt;
            tof_r <= tof_nxt;
        end
    end

    assign COUNTER_VALUE = cnt_r; // R9
    assign TOF_FLAG      = tof_r;
    assign TOF_IRQ       = tof_r & TMR_CFG.tof_ie; // R20 R26

    property p_cnt_write;
        COUNTER_WRITE |=> cnt_r == `TPM_CNT_ZERO && dir_r == DIR_UP;
    endproperty
    a_cnt_write: assert property (p_cnt_write) // R10
        else $error("counter not cleared by write");

    property p_free_wrap;
        cnt_tick && !COUNTER_WRITE && !TMR_CFG.center
            && TMR_CFG.modulo == `TPM_CNT_ZERO && cnt_r == `TPM_CNT_FULL
            |=> cnt_r == `TPM_CNT_ZERO && tof_r;
    endproperty
    a_free_wrap: assert property (p_free_wrap) // R8
        else $error("free-running wrap wrong");

    property p_debug_hold;
        BACKGROUND_DEBUG_MODE && !COUNTER_WRITE |=> $stable(cnt_r);
    endproperty
    a_debug_hold: assert property (p_debug_hold) // R11
        else $error("counter moved in debug mode");

    property p_center_turn;
        cnt_tick && !COUNTER_WRITE && TMR_CFG.center
            && dir_r == DIR_UP && cnt_r == TMR_CFG.modulo
            && TMR_CFG.modulo != `TPM_CNT_ZERO
            |=> dir_r == DIR_DOWN && cnt_r == $past(cnt_r) - `TPM_CNT_ONE;
    endproperty
    a_center_turn: assert property (p_center_turn) // R18
        else $error("center count did not turn at modulo");

    property p_tof_irq;
        tof_r && !TOF_CLEAR |=> tof_r ##0 TOF_IRQ == TMR_CFG.tof_ie;
    endproperty
    a_tof_irq: assert property (p_tof_irq) // R26
        else $error("terminal flag lost or interrupt wrong");

    property p_bus_step;
        TMR_CFG.clk_src == `TPM_CLK_BUS && TMR_CFG.prescale == 3'h0
            && !TMR_CFG.center && !BACKGROUND_DEBUG_MODE
            && !COUNTER_WRITE && cnt_r < TMR_CFG.modulo
            |=> cnt_r == $past(cnt_r) + `TPM_CNT_ONE;
    endproperty
    a_bus_step: assert property (p_bus_step) // R7
        else $error("undivided bus count did not step");

    c_center_turn: cover property (TMR_CFG.center && dir_r == DIR_DOWN);
    c_tof: cover property (tof_evt);

    // Channels
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            ch_cfg_t     cfg;
            logic        cap_mode;
            logic        cmp_mode;
            logic        edge_aligned_pwm_mode;
            logic        match;
            logic        cap_evt;
            logic        active;
            logic [15:0] val_r;
            logic [15:0] val_nxt;
            logic        flag_r;
            logic        flag_nxt;
            logic        out_r;
            logic        out_nxt;

            assign cfg = CH_CFG[gi];

            always_comb begin
                cap_mode  = !TMR_CFG.center && cfg.mode == `TPM_MS_CAPTURE
                            && clk_on; // R1 R2
                cmp_mode  = !TMR_CFG.center && cfg.mode == `TPM_MS_COMPARE;
                edge_aligned_pwm_mode = !TMR_CFG.center && cfg.mode[1];
                match     = adv_r && cnt_r == val_r && clk_on;
                cap_evt   = cap_mode
                            && els_edge(cfg.els, pin_rise[gi],
                                        pin_fall[gi]); // R14
                active    = ~cfg.els[0];
                val_nxt   = val_r;
                if (cap_evt) begin
                    val_nxt = cnt_r; // R13
                end else if (CHANNEL_VALUE_WRITE[gi]) begin
                    val_nxt = CHANNEL_VALUE_IN[gi];
                end
                out_nxt = out_r;
                if (TMR_CFG.center) begin
                    if (match) begin
                        out_nxt = (dir_r == DIR_DOWN) ? active
                                                      : ~active; // R19
                    end
                end else if (edge_aligned_pwm_mode) begin
                    if (match) begin
                        out_nxt = ~active; // R25
                    end else if (adv_r && cnt_r == `TPM_CNT_ZERO) begin
                        out_nxt = active; // R16 R25
                    end
                end else if (cmp_mode && match) begin
                    case (cfg.els)
                        `TPM_ELS_TOGGLE: out_nxt = ~out_r; // R15
                        `TPM_ELS_CLEAR:  out_nxt = 1'b0;
                        `TPM_ELS_SET:    out_nxt = 1'b1;
                        default:         out_nxt = out_r; // R22
                    endcase
                end
                flag_nxt = cap_evt
                           | (match && !cap_mode) // R15 R17
                           | (flag_r & ~CHANNEL_FLAG_CLEAR[gi]); // R26
            end

            always_ff @(posedge CLK or negedge rst_n) begin
                if (!rst_n) begin
                    val_r  <= `TPM_CNT_ZERO;
                    flag_r <= 1'b0;
                    out_r  <= 1'b0;
                end else begin
                    val_r  <= val_nxt;
                    flag_r <= flag_nxt;
                    out_r  <= out_nxt;
                end
            end

            assign CHANNEL_VALUE[gi]         = val_r;
            assign CHANNEL_FLAG[gi]          = flag_r;
            assign CHANNEL_IRQ[gi]           = flag_r & cfg.ie; // R20 R26
            assign TIMER_CHANNEL_PIN_OUT[gi] = out_r;
            assign TIMER_CHANNEL_PIN_OE_N[gi] =
                ~(clk_on && cfg.els != `TPM_ELS_OFF
                  && (TMR_CFG.center
                      || cfg.mode != `TPM_MS_CAPTURE)); // R21 R23

            property p_capture;
                cap_evt && !CHANNEL_FLAG_CLEAR[gi]
                    |=> val_r == $past(cnt_r) && flag_r;
            endproperty
            a_capture: assert property (p_capture) // R13
                else $error("capture did not latch counter");

            property p_release;
                cfg.els == `TPM_ELS_OFF || !clk_on
                    |-> TIMER_CHANNEL_PIN_OE_N[gi];
            endproperty
            a_release: assert property (p_release) // R23
                else $error("pin driven while released");

            property p_center_down;
                TMR_CFG.center && match && dir_r == DIR_DOWN
                    |=> out_r == ~cfg.els[0];
            endproperty
            a_center_down: assert property (p_center_down) // R19
                else $error("center match down not active");

            property p_edge_aligned_pwm_start;
                edge_aligned_pwm_mode && adv_r && cnt_r == `TPM_CNT_ZERO
                    && val_r != `TPM_CNT_ZERO && cfg.els == `TPM_ELS_FALL
                    |=> out_r;
            endproperty
            a_edge_aligned_pwm_start: assert property (p_edge_aligned_pwm_start) // R25
                else $error("edge PWM not high at period start");

            property p_cmp_set;
                cmp_mode && match && cfg.els == `TPM_ELS_SET
                    |=> out_r && flag_r;
            endproperty
            a_cmp_set: assert property (p_cmp_set) // R15
                else $error("compare set action missing");

            c_capture: cover property (cap_evt);
            c_edge_aligned_pwm: cover property (edge_aligned_pwm_mode && match);
        end
    endgenerate
endmodule
`default_nettype wire

// ===== verilog/tpm_defines.svh
// Constant names shared by the timer design files
// Summary of operation
// R1 - Each channel picks capture, compare or PWM
// R2 - One bit forces all channels center-aligned
// R3 - Prescaler divides by 1 to 128
// R4 - Clock source: none, bus, fixed, external
// R5 - Fixed clock synchronized before the prescaler
// R6 - External clock at most quarter bus rate
// R7 - 16-bit counter, free or modulo, up/down
// R8 - Modulo 0x0000 or 0xFFFF means free-running
// R9 - Reading the counter never disturbs counting
// R10 - Any counter write clears the counter
// R11 - Debug mode pauses all counting
// R12 - Runs in wait, idle in stop
// R13 - Capture edge copies counter, sets flag
// R14 - Capture edge rising, falling, both or none
// R15 - Compare match flags, then clears, sets, toggles
// R16 - Edge PWM period modulo plus one, polarity
// R17 - Edge PWM events at period end, duty
// R18 - Center PWM counts up then down
// R19 - Center match down activates, up deactivates
// R20 - Interrupt per channel plus terminal count
// R21 - Nothing enabled after reset, pins released
// R22 - External clock pin still allows software timer
// R23 - Pin released when select fields are zero
// R24 - Capture inputs synchronized, four-clock pulses seen
// R25 - Edge PWM high at zero, low on match
// R26 - Flags sticky, interrupt only when enabled
`ifndef TPM_DEFINES_SVH
`define TPM_DEFINES_SVH

`define TPM_CLK_NONE  2'h0
`define TPM_CLK_BUS   2'h1
`define TPM_CLK_FIXED 2'h2
`define TPM_CLK_EXT   2'h3

`define TPM_MS_CAPTURE 2'h0
`define TPM_MS_COMPARE 2'h1

`define TPM_ELS_OFF    2'h0
`define TPM_ELS_RISE   2'h1
`define TPM_ELS_FALL   2'h2
`define TPM_ELS_BOTH   2'h3
`define TPM_ELS_TOGGLE 2'h1
`define TPM_ELS_CLEAR  2'h2
`define TPM_ELS_SET    2'h3

`define TPM_CNT_ZERO 16'h0000
`define TPM_CNT_FULL 16'hFFFF
`define TPM_CNT_ONE  16'h0001
`define TPM_PRE_W    7
`define TPM_PRE_ONE  7'h01
`define TPM_PRE_ZERO 7'h00

`endif

// ===== verilog/tpm_pkg.sv
// Types shared by the timer design files
package tpm_pkg;

    typedef enum logic {
        DIR_UP   = 1'b0,
        DIR_DOWN = 1'b1
    } dir_t;

    typedef struct packed {
        logic        center;
        logic [1:0]  clk_src;
        logic [2:0]  prescale;
        logic [15:0] modulo;
        logic        tof_ie;
    } tmr_cfg_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] els;
        logic       ie;
    } ch_cfg_t;

endpackage

// ===== verilog/tpm_sync2.sv
// Two-stage synchronizer for asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module tpm_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire
